//--- core/iet_top.sv
`timescale 1ns/100ps
`include "iet_map.svh"
module iet_top #(
   parameter int NODES = 16,
   parameter int CHANS = 8,
   parameter int EXTS = 4
) (
   input logic clk, // System clock
   input logic rstn, // Async reset, active low
   input logic [8:0] address, // Avalon byte address
   input logic read, // Avalon read
   input logic write, // Avalon write
   input logic [31:0] writedata, // Avalon write data
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon wait
   input logic [NODES-1:0] node_req_in, // Peripheral request pulses
   input logic [EXTS-1:0] ext_pin, // Fast external interrupt pins
   input iet_pkg::iet_lvl_t cpu_level, // Level of running service
   input logic trap_req, // Trap instruction pulse
   input logic [7:0] trap_num, // Trap number
   output logic irq_req, // Interrupt request to CPU
   output logic [7:0] irq_num, // Trap number of request
   output logic [15:0] irq_vector, // Vector offset in segment
   output iet_pkg::iet_lvl_t irq_level, // Level of request
   input logic cpu_ack, // CPU accepted the interrupt
   output logic xfer_req, // Event transfer cycle request
   output iet_pkg::iet_addr_t xfer_src, // Transfer source address
   output iet_pkg::iet_addr_t xfer_dst, // Transfer destination address
   output logic xfer_word, // Word (1) or byte (0)
   input logic xfer_ack, // CPU gave the stolen cycle
   output logic sw_irq // Status interrupt, level
);
   import iet_pkg::*;

   localparam int NW = $clog2(NODES);
   localparam int CW = $clog2(CHANS);

   iet_state_t state_r;
   iet_lvl_t lvl_r [NODES];
   logic [NODES-1:0] en_r;
   logic [NODES-1:0] flag_r;
   logic [NODES-1:0] ev_r;
   logic [CW-1:0] ch_r [NODES];
   iet_addr_t src_r [CHANS];
   iet_addr_t dst_r [CHANS];
   logic [7:0] cnt_r [CHANS];
   logic [CHANS-1:0] cont_r;
   logic [CHANS-1:0] word_r;
   logic [CHANS-1:0] incs_r;
   logic [CHANS-1:0] incd_r;
   logic [1:0] edge_r [EXTS];
   logic [CHANS-1:0] status_r;
   logic [CHANS-1:0] mask_r;
   logic [EXTS-1:0] ext_hit;
   logic ack_r;
   logic [31:0] readdata_r;
   logic [31:0] rd_nxt;
   logic wr_en;
   logic rd_take;
   logic is_node;
   logic is_ch;
   logic [NW-1:0] a_node;
   logic [CW-1:0] a_ch;
   logic cand_found;
   logic [NW-1:0] cand_idx;
   iet_lvl_t cand_lvl;
   logic [CW-1:0] cand_ch;
   logic cand_ev;
   logic start_svc;
   logic [NW-1:0] cur_node_r;
   logic [CW-1:0] cur_ch_r;
   logic xfer_done;
   logic zero_hit;
   logic trap_pend_r;
   logic [7:0] trap_num_r;
   logic [7:0] irq_num_r;
   iet_lvl_t irq_level_r;
   iet_addr_t xfer_src_r;
   iet_addr_t xfer_dst_r;
   logic xfer_word_r;
   logic sw_irq_r;

   // ----------------------------------------------------------------
   // Avalon slave: one wait cycle, then the answer
   // ----------------------------------------------------------------
   // Wait is high on the first cycle of every request
   assign waitrequest = (read | write) & ~ack_r;
   assign wr_en = write & ack_r;
   assign rd_take = read & ack_r;
   assign readdata = readdata_r;
   assign is_node = (address[8:NW+2] == '0);
   assign is_ch = (address[8:7] == 2'h1);
   assign a_node = address[NW+1:2];
   assign a_ch = address[CW+3:4];

   // Acknowledge toggles so each request sees exactly one wait cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'h0;
      end else begin
         ack_r <= (read | write) & ~ack_r;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_nxt = `IET_RST_ZERO;
      if (is_node) begin
         rd_nxt[`IET_NODE_LVL_LSB +: 4] = lvl_r[a_node];
         rd_nxt[`IET_NODE_EN_BIT] = en_r[a_node];
         rd_nxt[`IET_NODE_REQ_BIT] = flag_r[a_node];
         rd_nxt[`IET_NODE_EV_BIT] = ev_r[a_node];
         rd_nxt[`IET_NODE_CH_LSB +: CW] = ch_r[a_node];
      end else if (is_ch) begin
         case (address[3:0])
            `IET_CH_SRC: rd_nxt[23:0] = src_r[a_ch];
            `IET_CH_DST: rd_nxt[23:0] = dst_r[a_ch];
            `IET_CH_CTL: begin
               rd_nxt[`IET_CH_CNT_LSB +: 8] = cnt_r[a_ch];
               rd_nxt[`IET_CH_CONT_BIT] = cont_r[a_ch];
               rd_nxt[`IET_CH_WORD_BIT] = word_r[a_ch];
               rd_nxt[`IET_CH_INCS_BIT] = incs_r[a_ch];
               rd_nxt[`IET_CH_INCD_BIT] = incd_r[a_ch];
            end
            default: rd_nxt = `IET_RST_ZERO;
         endcase
      end else if (address == `IET_EDGE_CFG) begin
         for (int i = 0; i < EXTS; i++) begin
            rd_nxt[2*i +: 2] = edge_r[i];
         end
      end else if (address == `IET_STATUS) begin
         rd_nxt[CHANS-1:0] = status_r;
      end else if (address == `IET_MASK) begin
         rd_nxt[CHANS-1:0] = mask_r;
      end
   end

   // Read data sampled in the wait cycle, stands at the answer edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata_r <= `IET_RST_ZERO;
      end else if (read && !ack_r) begin
         readdata_r <= rd_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fast external inputs
   // ----------------------------------------------------------------
   // Pin i feeds node i through its own edge detector
   for (genvar g = 0; g < EXTS; g++) begin : g_ext
      iet_edge_det u_edge (
         .clk(clk),
         .rstn(rstn),
         .pin_async(ext_pin[g]),
         .mode(edge_r[g]),
         .hit(ext_hit[g])
      );
   end

   // ----------------------------------------------------------------
   // Node control registers
   // ----------------------------------------------------------------
   // Level, enable, routing and channel select per node
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_r <= '0;
         ev_r <= '0;
         for (int i = 0; i < NODES; i++) begin
            lvl_r[i] <= 4'h0;
            ch_r[i] <= '0;
         end
      end else if (wr_en && is_node) begin
         lvl_r[a_node] <= writedata[`IET_NODE_LVL_LSB +: 4];
         en_r[a_node] <= writedata[`IET_NODE_EN_BIT];
         ev_r[a_node] <= writedata[`IET_NODE_EV_BIT];
         ch_r[a_node] <= writedata[`IET_NODE_CH_LSB +: CW];
      end
   end

   // Request flags: software write, then service clear, hardware set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= '0;
      end else begin
         for (int i = 0; i < NODES; i++) begin
            if (wr_en && is_node && a_node == NW'(i)) begin
               flag_r[i] <= writedata[`IET_NODE_REQ_BIT];
            end
            if (start_svc && cand_idx == NW'(i)) begin
               flag_r[i] <= 1'h0;
            end
            if (node_req_in[i] || (i < EXTS && ext_hit[i % EXTS]) ||
                (zero_hit && cur_node_r == NW'(i))) begin
               flag_r[i] <= 1'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------
   // Highest level above the running service; ties go to lowest index
   always_comb begin
      cand_found = 1'h0;
      cand_idx = '0;
      cand_lvl = 4'h0;
      for (int i = 0; i < NODES; i++) begin
         if (flag_r[i] && en_r[i] && lvl_r[i] > cpu_level &&
             (!cand_found || lvl_r[i] > cand_lvl)) begin
            cand_found = 1'h1;
            cand_idx = NW'(i);
            cand_lvl = lvl_r[i];
         end
      end
   end

   // An exhausted non-continuous channel falls back to the vector
   assign cand_ch = ch_r[cand_idx];
   assign cand_ev = ev_r[cand_idx] &&
                    (cont_r[cand_ch] || cnt_r[cand_ch] != 8'h00);
   assign start_svc = (state_r == IET_IDLE) && !trap_pend_r && cand_found;
   assign xfer_done = (state_r == IET_XFER) && xfer_ack;
   assign zero_hit = xfer_done && !cont_r[cur_ch_r] && cnt_r[cur_ch_r] == 8'h01;

   // ----------------------------------------------------------------
   // Trap capture
   // ----------------------------------------------------------------
   // A trap waits here until the sequencer is free
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trap_pend_r <= 1'h0;
         trap_num_r <= 8'h00;
      end else if (trap_req) begin
         trap_pend_r <= 1'h1;
         trap_num_r <= trap_num;
      end else if (state_r == IET_IDLE) begin
         trap_pend_r <= 1'h0;
      end
   end

   // ----------------------------------------------------------------
   // Service sequencer
   // ----------------------------------------------------------------
   // Request goes out the cycle after selection, well inside 8 clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= IET_IDLE;
         cur_node_r <= '0;
         cur_ch_r <= '0;
         irq_num_r <= 8'h00;
         irq_level_r <= 4'h0;
         xfer_src_r <= 24'h000000;
         xfer_dst_r <= 24'h000000;
         xfer_word_r <= 1'h0;
      end else begin
         case (state_r)
            IET_IDLE: begin
               if (trap_pend_r) begin
                  state_r <= IET_INT;
                  irq_num_r <= trap_num_r;
                  irq_level_r <= cpu_level;
               end else if (cand_found) begin
                  cur_node_r <= cand_idx;
                  cur_ch_r <= cand_ch;
                  irq_level_r <= cand_lvl;
                  irq_num_r <= `IET_NODE_TRAP_BASE + 8'(cand_idx);
                  if (cand_ev) begin
                     state_r <= IET_XFER;
                     xfer_src_r <= src_r[cand_ch];
                     xfer_dst_r <= dst_r[cand_ch];
                     xfer_word_r <= word_r[cand_ch];
                  end else begin
                     state_r <= IET_INT;
                  end
               end
            end
            IET_INT: begin
               if (cpu_ack) begin
                  state_r <= IET_IDLE;
               end
            end
            IET_XFER: begin
               if (xfer_ack) begin
                  state_r <= IET_IDLE;
               end
            end
            default: state_r <= IET_IDLE;
         endcase
      end
   end

   assign irq_req = (state_r == IET_INT);
   assign xfer_req = (state_r == IET_XFER);
   assign irq_num = irq_num_r;
   assign irq_vector = {6'h00, irq_num_r, 2'h0};
   assign irq_level = irq_level_r;
   assign xfer_src = xfer_src_r;
   assign xfer_dst = xfer_dst_r;
   assign xfer_word = xfer_word_r;

   // ----------------------------------------------------------------
   // Event transfer channels
   // ----------------------------------------------------------------
   // Pointers and counters: software writes, transfers update
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cont_r <= '0;
         word_r <= '0;
         incs_r <= '0;
         incd_r <= '0;
         for (int c = 0; c < CHANS; c++) begin
            src_r[c] <= 24'h000000;
            dst_r[c] <= 24'h000000;
            cnt_r[c] <= 8'h00;
         end
      end else if (xfer_done) begin
         if (incs_r[cur_ch_r]) begin
            src_r[cur_ch_r] <= src_r[cur_ch_r] + (word_r[cur_ch_r] ? 24'h2 : 24'h1);
         end
         if (incd_r[cur_ch_r]) begin
            dst_r[cur_ch_r] <= dst_r[cur_ch_r] + (word_r[cur_ch_r] ? 24'h2 : 24'h1);
         end
         if (!cont_r[cur_ch_r]) begin
            cnt_r[cur_ch_r] <= cnt_r[cur_ch_r] - 8'h01;
         end
      end else if (wr_en && is_ch) begin
         case (address[3:0])
            `IET_CH_SRC: src_r[a_ch] <= writedata[23:0];
            `IET_CH_DST: dst_r[a_ch] <= writedata[23:0];
            `IET_CH_CTL: begin
               cnt_r[a_ch] <= writedata[`IET_CH_CNT_LSB +: 8];
               cont_r[a_ch] <= writedata[`IET_CH_CONT_BIT];
               word_r[a_ch] <= writedata[`IET_CH_WORD_BIT];
               incs_r[a_ch] <= writedata[`IET_CH_INCS_BIT];
               incd_r[a_ch] <= writedata[`IET_CH_INCD_BIT];
            end
            default: cont_r <= cont_r;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Edge config, status, mask and interrupt output
   // ----------------------------------------------------------------
   // Edge selection per fast input
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < EXTS; i++) begin
            edge_r[i] <= 2'h0;
         end
      end else if (wr_en && address == `IET_EDGE_CFG) begin
         for (int i = 0; i < EXTS; i++) begin
            edge_r[i] <= writedata[2*i +: 2];
         end
      end
   end

   // Sticky count-zero bits; read clears what was seen, set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~((rd_take && address == `IET_STATUS) ?
                     readdata_r[CHANS-1:0] : '0)) |
                     (zero_hit ? (CHANS'(1) << cur_ch_r) : '0);
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= '0;
      end else if (wr_en && address == `IET_MASK) begin
         mask_r <= writedata[CHANS-1:0];
      end
   end

   // Level interrupt while any unmasked status bit is set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_irq_r <= 1'h0;
      end else begin
         sw_irq_r <= |(status_r & mask_r);
      end
   end

   assign sw_irq = sw_irq_r;
endmodule : iet_top

//--- core/iet_map.svh
// What this block does
// - Service starts well within eight clocks typically
// - Each node selects interrupt or event transfer
// - Event transfer steals one cycle, no vector
// - Move byte or word, bump chosen pointers
// - Channel counter decrements unless continuous mode
// - Counter reaching zero raises node's standard interrupt
// - Eight independent event transfer channels
// - Node control holds request, enable, priority
// - Priority field selects one of sixteen levels
// - Only strictly higher priority preempts running service
// - Every node owns a distinct vector location
// - Fast inputs detect rising, falling or both
// - Trap instruction number selects interrupt entered
// - Software setting a request flag raises request
`ifndef IET_MAP_SVH
`define IET_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define IET_NODE_BASE 9'h000
`define IET_CH_BASE 9'h080
`define IET_CH_SRC 4'h0
`define IET_CH_DST 4'h4
`define IET_CH_CTL 4'h8
`define IET_EDGE_CFG 9'h100
`define IET_STATUS 9'h104
`define IET_MASK 9'h108

// ----------------------------------------------------------------
// Node control fields
// ----------------------------------------------------------------
`define IET_NODE_LVL_LSB 0
`define IET_NODE_EN_BIT 6
`define IET_NODE_REQ_BIT 7
`define IET_NODE_EV_BIT 8
`define IET_NODE_CH_LSB 9

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define IET_CH_CNT_LSB 0
`define IET_CH_CONT_BIT 8
`define IET_CH_WORD_BIT 9
`define IET_CH_INCS_BIT 10
`define IET_CH_INCD_BIT 11

// ----------------------------------------------------------------
// Edge modes, vectors, reset values, timing
// ----------------------------------------------------------------
`define IET_EDGE_RISE_BIT 0
`define IET_EDGE_FALL_BIT 1
`define IET_NODE_TRAP_BASE 8'h10
`define IET_RST_ZERO 32'h0000_0000
`define IET_RESP_TYP_CYC 8

`endif

//--- core/iet_pkg.sv
package iet_pkg;
   typedef enum logic [1:0] {IET_IDLE, IET_INT, IET_XFER} iet_state_t;
   typedef logic [23:0] iet_addr_t;
   typedef logic [3:0] iet_lvl_t;
endpackage : iet_pkg

//--- core/iet_edge_det.sv
`timescale 1ns/100ps
`include "iet_map.svh"
module iet_edge_det (
   input logic clk, // System clock
   input logic rstn, // Async reset, active low
   input logic pin_async, // Raw fast interrupt pin
   input logic [1:0] mode, // Edge selection
   output logic hit // One-cycle edge pulse
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic hit_r;

   // ----------------------------------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------------------------------
   // Two flops first, then edge compare on the second and third
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 1'h0;
         sync2_r <= 1'h0;
         prev_r <= 1'h0;
         hit_r <= 1'h0;
      end else begin
         sync1_r <= pin_async;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         hit_r <= (mode[`IET_EDGE_RISE_BIT] & sync2_r & ~prev_r) |
                  (mode[`IET_EDGE_FALL_BIT] & ~sync2_r & prev_r);
      end
   end

   assign hit = hit_r;
endmodule : iet_edge_det

//--- verification/iet_top_properties.sv
`timescale 1ns/100ps
module iet_props
   import iet_pkg::*;
#(
   parameter int NODES = 16
) (
   input logic clk, // Clock
   input logic rstn, // Reset, active low
   input logic read, // Read
   input logic write, // Write
   input logic waitrequest, // Wait
   input iet_pkg::iet_lvl_t cpu_level, // Core level
   input logic trap_req, // Trap
   input logic [7:0] trap_num, // Trap number
   input logic irq_req, // Irq
   input logic [7:0] irq_num, // Irq number
   input logic [15:0] irq_vector, // Vector
   input iet_pkg::iet_lvl_t irq_level, // Irq level
   input logic cpu_ack, // Irq taken
   input logic xfer_req, // Xfer
   input iet_pkg::iet_addr_t xfer_src, // Source
   input iet_pkg::iet_addr_t xfer_dst, // Destination
   input logic xfer_word, // Width
   input logic xfer_ack // Xfer done
);
   // ----------------------------------------------------------------
   // Helper state and checks
   // ----------------------------------------------------------------
   logic [7:0] trap_hold_r;

   // Last trap number
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trap_hold_r <= 8'h00;
      end else if (trap_req) begin
         trap_hold_r <= trap_num;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   AST_NO_BOTH: assert property (!(irq_req && xfer_req))
      else $error("irq and xfer together");
   AST_XFER_ONE: assert property (xfer_req && xfer_ack |=> !xfer_req && !irq_req)
      else $error("xfer outlived one cycle");
   AST_XFER_STABLE: assert property (xfer_req && !xfer_ack |=>
      xfer_req && $stable(xfer_src) && $stable(xfer_dst) && $stable(xfer_word))
      else $error("xfer fields moved");
   AST_IRQ_HOLD: assert property (irq_req && !cpu_ack |=> irq_req && $stable(irq_num))
      else $error("irq dropped or changed");
   AST_IRQ_DONE: assert property (irq_req && cpu_ack |=> !irq_req && !xfer_req)
      else $error("irq stayed after ack");
   AST_VEC_MAP: assert property (irq_req |-> irq_vector == {6'h00, irq_num, 2'h0})
      else $error("vector mismatch");
   AST_LVL_ABOVE: assert property ($rose(irq_req) && irq_num >= 8'h10
      && irq_num < 8'h10 + 8'(NODES) |-> irq_level > cpu_level)
      else $error("level not above core");
   AST_TRAP_NUM: assert property (trap_req && !irq_req && !xfer_req |->
      ##[1:4] (irq_req && irq_num == trap_hold_r))
      else $error("trap not entered");
   AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait over one cycle");
endmodule : iet_props

bind iet_top iet_props #(.NODES(NODES)) u_props (.*);

//--- verification/iet_cpu_model.sv
`timescale 1ns/100ps
module iet_cpu_model (
   input logic clk, // System clock
   input logic rstn, // Async reset, active low
   input logic [2:0] slow, // Answer delay
   input logic irq_req, // Interrupt request
   input logic xfer_req, // Transfer request
   output logic cpu_ack, // Interrupt accepted
   output logic xfer_ack // Stolen cycle done
);
   // ----------------------------------------------------------------
   // Core side: answers one request at a time
   // ----------------------------------------------------------------
   logic [2:0] wait_r;

   // One-cycle ack after the wait
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_ack <= 1'b0;
         xfer_ack <= 1'b0;
         wait_r <= 3'h0;
      end else begin
         cpu_ack <= 1'b0;
         xfer_ack <= 1'b0;
         if ((irq_req && !cpu_ack) || (xfer_req && !xfer_ack)) begin
            if (wait_r >= slow) begin
               wait_r <= 3'h0;
               cpu_ack <= irq_req;
               xfer_ack <= xfer_req && !irq_req; // Single stolen cycle
            end else begin
               wait_r <= wait_r + 3'h1;
            end
         end
      end
   end
endmodule : iet_cpu_model

//--- verification/iet_top_tb_top.sv
`timescale 1ns/100ps
`include "iet_map.svh"
module iet_top_tb_top;
   import iet_pkg::*;
   logic clk, rstn, read, write, waitrequest, trap_req, irq_req, cpu_ack, xfer_req;
   logic xfer_word, xfer_ack, sw_irq;
   logic [8:0] address;
   logic [31:0] writedata, readdata, q, s, d, mask;
   logic [15:0] node_req_in, irq_vector;
   logic [3:0] ext_pin, lv;
   logic [7:0] trap_num, irq_num, tn;
   logic [2:0] slow;
   iet_lvl_t cpu_level, irq_level;
   iet_addr_t xfer_src, xfer_dst;
   int fail_count, tests_run, seed, st, n;
   logic [19:0] irq_q[$];
   logic [48:0] xfer_q[$];

   // ----------------------------------------------------------------
   // Design, core model, clock, monitor
   // ----------------------------------------------------------------
   iet_top dut_u (.*);
   iet_cpu_model cpu_u (.*);
   always #5 clk = ~clk;

   // Log accepted services
   always @(posedge clk) begin
      if ((cpu_ack & irq_req) === 1'b1) irq_q.push_back({irq_level, irq_vector});
      if ((xfer_ack & xfer_req) === 1'b1) xfer_q.push_back({xfer_word, xfer_src, xfer_dst});
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] nc(input int lvl, en, rq, ev, ch);
      return 32'(lvl) | 32'(en) << `IET_NODE_EN_BIT | 32'(rq) << `IET_NODE_REQ_BIT
         | 32'(ev) << `IET_NODE_EV_BIT | 32'(ch) << `IET_NODE_CH_LSB;
   endfunction : nc
   function automatic logic [31:0] cc(input int c, cnt, ct);
      return 32'(cnt) | 32'(ct) << `IET_CH_CONT_BIT | (32'(c) & 32'h7) << `IET_CH_WORD_BIT;
   endfunction : cc
   function automatic logic [8:0] ca(input int c, input logic [3:0] off);
      return `IET_CH_BASE + 9'(16 * c) + 9'(off);
   endfunction : ca
   function automatic logic [63:0] iv(input logic [3:0] lvl, input logic [7:0] num);
      return {44'h0, lvl, 6'h00, num, 2'h0};
   endfunction : iv
   task automatic chk(input logic [63:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] dat);
      int k = 0;
      @(posedge clk);
      address <= a;
      writedata <= dat;
      {write, read} <= {wr, !wr};
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 20);
      if (k >= 20) fail_count++;
      q = readdata;
      {read, write} <= 2'b00;
   endtask : bus
   task automatic rd(input logic [8:0] a, input logic [63:0] e, input string w);
      bus(1'b0, a, 32'h0);
      chk(q, e, w);
   endtask : rd
   task automatic take(input bit xf, input logic [63:0] e);
      int k = 0;
      while ((xf ? xfer_q.size() : irq_q.size()) == 0 && k < 60) begin
         @(posedge clk);
         k++;
      end
      if (k >= 60) chk(0, e, "no answer");
      else if (xf) chk(xfer_q.pop_front(), e, "transfer");
      else chk(irq_q.pop_front(), e, "interrupt");
   endtask : take
   task automatic quiet(input int c);
      repeat (c) @(posedge clk);
      chk(irq_q.size() + xfer_q.size(), 0, "idle");
   endtask : quiet
   task automatic hit(input logic [15:0] m);
      @(posedge clk);
      node_req_in <= m;
      @(posedge clk);
      node_req_in <= 16'h0000;
   endtask : hit
   task automatic conclude();
      if (fail_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude

   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {clk, rstn, read, write, trap_req} = 5'h00;
      {address, writedata, node_req_in, ext_pin, cpu_level, trap_num, slow} = 0;
      seed = 37688;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      chk({irq_req, xfer_req, sw_irq}, 0, "reset");
      for (int i = 0; i < 16; i++) bus(1'b1, 9'(4 * i), nc(i, 0, 0, 0, i % 8));
      for (int i = 0; i < 16; i++) rd(9'(4 * i), nc(i, 0, 0, 0, i % 8), "node");
      rd(9'h1F0, 0, "unmapped");
      // Software flags reach own vectors
      for (int i = 0; i < 16; i++) begin
         lv = 4'(1 + $unsigned($random(seed)) % 15);
         bus(1'b1, 9'(4 * i), nc(lv, 1, 1, 0, 0));
         take(0, iv(lv, 8'h10 + 8'(i)));
         rd(9'(4 * i), nc(lv, 1, 0, 0, 0), "flag");
      end
      // Higher level first, then lowest index
      bus(1'b1, 9'h014, nc(7, 1, 0, 0, 0));
      bus(1'b1, 9'h024, nc(7, 1, 0, 0, 0));
      bus(1'b1, 9'h030, nc(9, 1, 0, 0, 0));
      slow <= 3'h3;
      hit(16'h1220);
      take(0, iv(9, 8'h1C));
      take(0, iv(7, 8'h15));
      take(0, iv(7, 8'h19));
      // Equal level waits for core level to drop
      cpu_level <= 4'h7;
      hit(16'h0020);
      quiet(12);
      rd(9'h014, nc(7, 1, 1, 0, 0), "held");
      cpu_level <= 4'h6;
      take(0, iv(7, 8'h15));
      slow <= 3'h0;
      hit(16'h0200);
      n = 0;
      while (irq_req !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      chk(irq_req, 1, "latency");
      take(0, iv(7, 8'h19));
      // Trap entry with its own number
      tn = 8'h80 | 8'($random(seed));
      cpu_level <= 4'h2;
      @(posedge clk);
      trap_req <= 1'b1;
      trap_num <= tn;
      @(posedge clk);
      trap_req <= 1'b0;
      take(0, iv(2, tn));
      // Channels: two transfers, then count-zero interrupt
      mask = $random(seed);
      bus(1'b1, `IET_MASK, mask);
      cpu_level <= 4'h0;
      for (int c = 0; c < 8; c++) begin
         s = $random(seed) & 32'h00FF_FFF0;
         d = $random(seed) & 32'h00FF_FFF0;
         st = c[0] ? 2 : 1;
         slow <= 3'($unsigned($random(seed)) % 5);
         bus(1'b1, ca(c, `IET_CH_SRC), s);
         bus(1'b1, ca(c, `IET_CH_DST), d);
         bus(1'b1, ca(c, `IET_CH_CTL), cc(c, 2, 0));
         bus(1'b1, 9'(4 * c), nc(1, 1, 0, 1, c));
         hit(16'h0001 << c);
         take(1, {c[0], s[23:0], d[23:0]});
         rd(ca(c, `IET_CH_CTL), cc(c, 1, 0), "count");
         hit(16'h0001 << c);
         take(1, {c[0], 24'(s + st * c[1]), 24'(d + st * c[2])});
         take(0, iv(1, 8'h10 + 8'(c)));
         repeat (3) @(posedge clk);
         chk(sw_irq, mask[c], "sw_irq");
         rd(`IET_STATUS, 32'h1 << c, "status");
         rd(`IET_STATUS, 0, "status clr");
         repeat (2) @(posedge clk);
         chk(sw_irq, 0, "sw_irq clr");
         bus(1'b1, 9'(4 * c), 32'h0);
      end
      // Continuous mode keeps its count
      bus(1'b1, ca(3, `IET_CH_SRC), s);
      bus(1'b1, ca(3, `IET_CH_DST), d);
      bus(1'b1, ca(3, `IET_CH_CTL), cc(0, 1, 1));
      bus(1'b1, 9'h00C, nc(1, 1, 0, 1, 3));
      repeat (2) begin
         hit(16'h0008);
         take(1, {1'b0, s[23:0], d[23:0]});
      end
      quiet(12);
      rd(ca(3, `IET_CH_CTL), cc(0, 1, 1), "cont count");
      // Fast pin edge modes
      bus(1'b1, 9'h000, nc(2, 1, 0, 0, 0));
      for (int m = 1; m < 4; m++) begin
         bus(1'b1, `IET_EDGE_CFG, 32'(m));
         ext_pin[0] <= 1'b1;
         if (m[0]) take(0, iv(2, 8'h10));
         else quiet(12);
         ext_pin[0] <= 1'b0;
         if (m[1]) take(0, iv(2, 8'h10));
         else quiet(12);
      end
      conclude();
   end
endmodule : iet_top_tb_top
